/* verilog/iobx_pkg.sv */
package iobx_pkg;
	// instruction word layout
	localparam int INSTR_W = 14;
	localparam int DATA_W = 8;
	localparam int FADDR_W = 7;
	localparam int PC_W = 15;
	localparam int LATCH_W = 7;
	localparam int BR_LIT_W = 11;
	localparam int OP_MSB = 13;
	localparam int OP_LSB = 8;
	localparam int DEST_BIT = 7;
	localparam int BR_OP_LSB = 11;
	localparam int LATCH_HI = 6;
	localparam int LATCH_LO = 3;
	// opcode field values
	localparam logic [5:0] OP_DEC = 6'h03;
	localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
	localparam logic [5:0] OP_INC = 6'h0A;
	localparam logic [5:0] OP_INC_SKIP = 6'h0F;
	localparam logic [5:0] OP_OR_LIT = 6'h38;
	localparam logic [2:0] OP_BRANCH = 3'h5;
	// reset values and arithmetic constants
	localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
	localparam logic [PC_W-1:0] PC_RST = 15'h0000;
	localparam logic [DATA_W-1:0] ONE = 8'h01;
	localparam logic [DATA_W-1:0] ZERO = 8'h00;
	// execution sequencer
	typedef enum logic [1:0] {
		ST_FETCH,
		ST_EXEC,
		ST_SKIP,
		ST_BRANCH
	} iobx_state_type;
endpackage

/* verilog/iobx_mem_if.sv */
`timescale 1ns/1ps
interface iobx_mem_if;
	logic rd_en;
	logic [iobx_pkg::FADDR_W-1:0] rd_addr;
	logic [iobx_pkg::DATA_W-1:0] rd_data;
	logic wr_en;
	logic [iobx_pkg::FADDR_W-1:0] wr_addr;
	logic [iobx_pkg::DATA_W-1:0] wr_data;
	modport core (output rd_en, rd_addr, wr_en, wr_addr, wr_data,
		input rd_data);
	modport mem (input rd_en, rd_addr, wr_en, wr_addr, wr_data,
		output rd_data);
endinterface

/* verilog/iobx_file_mem.sv */
`timescale 1ns/1ps
module iobx_file_mem #(
	parameter int AW = iobx_pkg::FADDR_W,
	parameter int DW = iobx_pkg::DATA_W
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	iobx_mem_if.mem port
);
	logic [DW-1:0] cells [0:(1<<AW)-1];
	logic [DW-1:0] rd_q;
	logic [DW-1:0] rd_d;

	// the interface fixes the widths, so anything else is refused
	if (AW != iobx_pkg::FADDR_W || DW != iobx_pkg::DATA_W) begin : g_chk
		$error("iobx_file_mem: width parameters do not match interface");
	end

	// read data always leaves from a register
	always_comb begin
		rd_d = rd_q;
		if (port.rd_en) begin
			rd_d = cells[port.rd_addr];
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rd_q <= iobx_pkg::ZERO;
		end else begin
			rd_q <= rd_d;
		end
	end

	// cells hold no reset, like real data memory
	always_ff @(posedge clk_in) begin
		if (port.wr_en) begin
			cells[port.wr_addr] <= port.wr_data;
		end
	end

	assign port.rd_data = rd_q;
endmodule

/* verilog/iobx_core.sv */
`timescale 1ns/1ps
module iobx_core (
	input wire logic CORE_CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [13:0] INSTR_IN,
	input wire logic INSTR_VALID_IN,
	input wire logic [6:0] PC_LATCH_IN,
	input wire logic LOAD_WE_IN,
	input wire logic [6:0] LOAD_ADDR_IN,
	input wire logic [7:0] LOAD_DATA_IN,
	output logic INSTR_READY_OUT,
	output logic [7:0] ACCUM_OUT,
	output logic ZERO_FLAG_OUT,
	output logic [14:0] PC_OUT,
	output logic FILE_WE_OUT,
	output logic [6:0] FILE_ADDR_OUT,
	output logic [7:0] FILE_DATA_OUT
);
	logic [1:0] rst_sync_q;
	logic rst_n;
	iobx_pkg::iobx_state_type st_q, st_d;
	logic [13:0] ir_q, ir_d;
	logic [7:0] w_q, w_d;
	logic z_q, z_d;
	logic [14:0] pc_q, pc_d;
	logic rdy_q, rdy_d;
	logic fwe_q, fwe_d;
	logic [6:0] fad_q, fad_d;
	logic [7:0] fdat_q, fdat_d;
	logic take;
	logic [5:0] op;
	logic is_branch;
	logic [7:0] res;
	logic core_we;
	logic [14:0] br_target;
	iobx_mem_if mem ();

	// reset released through two flops, asserted at once
	always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// decode of the held instruction
	assign take = INSTR_VALID_IN && rdy_q;
	assign op = ir_q[iobx_pkg::OP_MSB:iobx_pkg::OP_LSB];
	assign is_branch = ir_q[iobx_pkg::OP_MSB:iobx_pkg::BR_OP_LSB]
		== iobx_pkg::OP_BRANCH;
	assign br_target = {PC_LATCH_IN[iobx_pkg::LATCH_HI:iobx_pkg::LATCH_LO],
		ir_q[iobx_pkg::BR_LIT_W-1:0]};

	// file operand fetched while the instruction is taken
	assign mem.rd_en = take && st_q == iobx_pkg::ST_FETCH;
	assign mem.rd_addr = INSTR_IN[iobx_pkg::FADDR_W-1:0];
	// preload only lands when the core is not writing back
	assign mem.wr_en = core_we || LOAD_WE_IN;
	assign mem.wr_addr = core_we ? ir_q[iobx_pkg::FADDR_W-1:0] : LOAD_ADDR_IN;
	assign mem.wr_data = core_we ? res : LOAD_DATA_IN;

	iobx_file_mem #(
		.AW(iobx_pkg::FADDR_W),
		.DW(iobx_pkg::DATA_W)
	) u_mem (
		.clk_in(CORE_CLK_IN),
		.rst_n_in(rst_n),
		.port(mem.mem)
	);

	// sequencer and architectural state, next values
	always_comb begin
		st_d = st_q;
		ir_d = ir_q;
		w_d = w_q;
		z_d = z_q;
		pc_d = pc_q;
		fwe_d = 1'b0;
		fad_d = fad_q;
		fdat_d = fdat_q;
		res = iobx_pkg::ZERO;
		core_we = 1'b0;
		case (st_q)
			iobx_pkg::ST_FETCH: begin
				if (take) begin
					ir_d = INSTR_IN;
					pc_d = pc_q + 15'h0001;
					st_d = iobx_pkg::ST_EXEC;
				end
			end
			iobx_pkg::ST_EXEC: begin
				st_d = iobx_pkg::ST_FETCH;
				if (op == iobx_pkg::OP_DEC || op == iobx_pkg::OP_DEC_SKIP) begin
					res = mem.rd_data - iobx_pkg::ONE;
				end else if (op == iobx_pkg::OP_INC
					|| op == iobx_pkg::OP_INC_SKIP) begin
					res = mem.rd_data + iobx_pkg::ONE;
				end else if (op == iobx_pkg::OP_OR_LIT) begin
					res = w_q | ir_q[iobx_pkg::DATA_W-1:0];
				end
				if (op == iobx_pkg::OP_DEC || op == iobx_pkg::OP_DEC_SKIP
					|| op == iobx_pkg::OP_INC || op == iobx_pkg::OP_INC_SKIP) begin
					// destination bit picks file or accumulator
					if (ir_q[iobx_pkg::DEST_BIT]) begin
						core_we = 1'b1;
						fwe_d = 1'b1;
						fad_d = ir_q[iobx_pkg::FADDR_W-1:0];
						fdat_d = res;
					end else begin
						w_d = res;
					end
					// skip forms discard the next word on zero
					if (op != iobx_pkg::OP_DEC && op != iobx_pkg::OP_INC
						&& res == iobx_pkg::ZERO) begin
						st_d = iobx_pkg::ST_SKIP;
					end
				end
				if (op == iobx_pkg::OP_OR_LIT) begin
					w_d = res;
				end
				// skip forms and branch leave the flag alone
				if (op == iobx_pkg::OP_DEC || op == iobx_pkg::OP_INC
					|| op == iobx_pkg::OP_OR_LIT) begin
					z_d = (res == iobx_pkg::ZERO);
				end
				if (is_branch) begin
					pc_d = br_target;
					st_d = iobx_pkg::ST_BRANCH;
				end
			end
			iobx_pkg::ST_SKIP: begin
				// skipped word still advances the counter
				if (take) begin
					pc_d = pc_q + 15'h0001;
					st_d = iobx_pkg::ST_FETCH;
				end
			end
			default: begin
				// word fetched behind a branch is flushed
				if (take) begin
					st_d = iobx_pkg::ST_FETCH;
				end
			end
		endcase
		rdy_d = (st_d != iobx_pkg::ST_EXEC);
	end

	always_ff @(posedge CORE_CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= iobx_pkg::ST_FETCH;
			ir_q <= 14'h0000;
			w_q <= iobx_pkg::ACCUM_RST;
			z_q <= 1'b0;
			pc_q <= iobx_pkg::PC_RST;
			rdy_q <= 1'b0;
			fwe_q <= 1'b0;
			fad_q <= 7'h00;
			fdat_q <= iobx_pkg::ZERO;
		end else begin
			st_q <= st_d;
			ir_q <= ir_d;
			w_q <= w_d;
			z_q <= z_d;
			pc_q <= pc_d;
			rdy_q <= rdy_d;
			fwe_q <= fwe_d;
			fad_q <= fad_d;
			fdat_q <= fdat_d;
		end
	end

	assign INSTR_READY_OUT = rdy_q;
	assign ACCUM_OUT = w_q;
	assign ZERO_FLAG_OUT = z_q;
	assign PC_OUT = pc_q;
	assign FILE_WE_OUT = fwe_q;
	assign FILE_ADDR_OUT = fad_q;
	assign FILE_DATA_OUT = fdat_q;

	// checks on the execution stage
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!rst_n);

	logic ex;
	assign ex = (st_q == iobx_pkg::ST_EXEC);

	sequence s_skip_hit;
		ex && (op == iobx_pkg::OP_DEC_SKIP || op == iobx_pkg::OP_INC_SKIP)
			&& res == iobx_pkg::ZERO;
	endsequence
	sequence s_skip_drop;
		st_q == iobx_pkg::ST_SKIP && take ##1 st_q == iobx_pkg::ST_FETCH;
	endsequence

	a_dec_to_accum: assert property (ex && op == iobx_pkg::OP_DEC
		&& !ir_q[7] |=> w_q == $past(mem.rd_data) - 8'h01)
		else $error("decrement into accumulator wrong");
	a_dec_skip_file: assert property (ex && op == iobx_pkg::OP_DEC_SKIP
		&& ir_q[7] |-> core_we && mem.wr_data == mem.rd_data - 8'h01)
		else $error("decrement-skip write back wrong");
	a_skip_discards: assert property (s_skip_hit ##1 s_skip_drop
		|-> $stable(w_q) && !fwe_q)
		else $error("skipped word was executed");
	a_skip_enters: assert property (s_skip_hit |=>
		st_q == iobx_pkg::ST_SKIP && rdy_q)
		else $error("zero result did not skip");
	a_branch_target: assert property (ex && is_branch
		|=> pc_q == $past(br_target) && st_q == iobx_pkg::ST_BRANCH)
		else $error("branch target wrong");
	// the second branch cycle is the flushed word, however soon it comes
	a_branch_flags: assert property (ex && is_branch |=> $stable(z_q)
		&& st_q == iobx_pkg::ST_BRANCH && rdy_q)
		else $error("branch touched flag or ran short");
	a_branch_drop: assert property (st_q == iobx_pkg::ST_BRANCH && take
		|=> st_q == iobx_pkg::ST_FETCH && $stable(pc_q) && $stable(w_q))
		else $error("word behind branch was executed");
	a_inc_file: assert property (ex && op == iobx_pkg::OP_INC
		&& ir_q[7] |=> fwe_q && fdat_q == $past(mem.rd_data) + 8'h01)
		else $error("increment write back wrong");
	a_or_literal: assert property (ex && op == iobx_pkg::OP_OR_LIT
		|=> w_q == ($past(w_q) | $past(ir_q[7:0])))
		else $error("or literal result wrong");
	a_incsz_flag: assert property (ex && op == iobx_pkg::OP_INC_SKIP
		|=> $stable(z_q))
		else $error("increment-skip changed flag");
	a_zero_flag: assert property (ex && (op == iobx_pkg::OP_DEC
		|| op == iobx_pkg::OP_INC) |=> z_q == ($past(res) == 8'h00))
		else $error("zero flag wrong");
endmodule

/* tb/iobx_core_tb_top.sv */
`timescale 1ns/1ps
module iobx_core_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [13:0] instr = 14'h0000;
	logic valid = 1'b0;
	logic [6:0] latch = 7'h00;
	logic ld_we = 1'b0;
	logic [6:0] ld_addr = 7'h00;
	logic [7:0] ld_data = 8'h00;
	logic ready, zero, fwe;
	logic [7:0] accum, fdata;
	logic [6:0] faddr;
	logic [14:0] pc;
	logic [14:0] pc_e = 15'h0000;
	int n_mismatch = 0;
	int total_checks = 0;

	// free-running core clock, 20 ns period
	always #10 clk = ~clk;

	iobx_core iobx_core_i (
		.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .INSTR_IN(instr),
		.INSTR_VALID_IN(valid), .PC_LATCH_IN(latch), .LOAD_WE_IN(ld_we),
		.LOAD_ADDR_IN(ld_addr), .LOAD_DATA_IN(ld_data),
		.INSTR_READY_OUT(ready), .ACCUM_OUT(accum), .ZERO_FLAG_OUT(zero),
		.PC_OUT(pc), .FILE_WE_OUT(fwe), .FILE_ADDR_OUT(faddr),
		.FILE_DATA_OUT(fdata)
	);

	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one compare task per kind of result: data, flag, pc
	task automatic chk8(input logic [7:0] g, input logic [7:0] e, string m);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e, string m);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %b exp %b", $time, m, g, e);
		end
	endtask
	task automatic chk15(input logic [14:0] g, input logic [14:0] e, string m);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	function automatic logic [13:0] fop(logic [5:0] o, logic d, logic [6:0] a);
		return {o, d, a};
	endfunction

	// preload one byte while the core is idle
	task automatic load(input logic [6:0] a, input logic [7:0] d);
		ld_we = 1'b1;
		ld_addr = a;
		ld_data = d;
		@(posedge clk);
		#1 ld_we = 1'b0;
		// one idle edge, so back-to-back loads never retoggle the strobe
		@(posedge clk);
		#1;
	endtask

	// offer a word, then return just after its execute edge
	task automatic issue(input logic [13:0] w);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 10) begin
			n_mismatch++;
			final_report();
		end
		instr = w;
		valid = 1'b1;
		@(posedge clk);
		#1 valid = 1'b0;
		pc_e = pc_e + 15'h0001;
		@(posedge clk);
		#1;
	endtask

	task automatic t_dec();
		load(7'h20, 8'h01);
		issue(fop(iobx_pkg::OP_DEC, 1'b0, 7'h20));
		chk8(accum, 8'h00, "dec to w");
		chk1(zero, 1'b1, "dec zero");
		chk1(fwe, 1'b0, "dec d0 write");
		issue(fop(iobx_pkg::OP_DEC, 1'b1, 7'h20));
		chk1(fwe, 1'b1, "dec d1 write");
		chk8({1'b0, faddr}, 8'h20, "dec addr");
		chk8(fdata, 8'h00, "dec data");
		issue(fop(iobx_pkg::OP_DEC, 1'b1, 7'h20));
		chk8(fdata, 8'hFF, "dec wrap");
		chk1(zero, 1'b0, "dec nonzero");
		chk8(accum, 8'h00, "dec w kept");
		$display("test dec done");
	endtask

	task automatic t_or();
		issue({iobx_pkg::OP_OR_LIT, 8'h00});
		chk1(zero, 1'b1, "or zero");
		issue({iobx_pkg::OP_OR_LIT, 8'h5A});
		chk8(accum, 8'h5A, "or 5a");
		chk1(zero, 1'b0, "or nonzero");
		issue({iobx_pkg::OP_OR_LIT, 8'hA5});
		chk8(accum, 8'hFF, "or ff");
		$display("test or done");
	endtask

	// valid held through the execute cycle must not be taken twice
	task automatic t_ready();
		instr = {iobx_pkg::OP_OR_LIT, 8'h00};
		valid = 1'b1;
		@(posedge clk);
		#1 chk1(ready, 1'b0, "busy in exec");
		pc_e = pc_e + 15'h0001;
		@(posedge clk);
		#1 valid = 1'b0;
		chk1(ready, 1'b1, "ready after exec");
		chk8(accum, 8'hFF, "or once");
		chk15(pc, pc_e, "one word taken");
		$display("test ready done");
	endtask

	task automatic t_inc();
		load(7'h10, 8'hFF);
		issue(fop(iobx_pkg::OP_INC, 1'b1, 7'h10));
		chk1(fwe, 1'b1, "inc write");
		chk8(fdata, 8'h00, "inc wrap");
		chk1(zero, 1'b1, "inc zero");
		chk8(accum, 8'hFF, "inc w kept");
		issue(fop(iobx_pkg::OP_INC, 1'b0, 7'h10));
		chk8(accum, 8'h01, "inc to w");
		chk1(zero, 1'b0, "inc nonzero");
		chk1(fwe, 1'b0, "inc d0 write");
		$display("test inc done");
	endtask

	// skip miss runs the next word, skip hit drops it
	task automatic t_skip();
		load(7'h30, 8'h02);
		load(7'h31, 8'h01);
		load(7'h32, 8'hFF);
		issue(fop(iobx_pkg::OP_DEC_SKIP, 1'b0, 7'h30));
		chk8(accum, 8'h01, "decsz to w");
		issue({iobx_pkg::OP_OR_LIT, 8'h80});
		chk8(accum, 8'h81, "decsz miss");
		issue(fop(iobx_pkg::OP_DEC_SKIP, 1'b1, 7'h31));
		chk1(fwe, 1'b1, "decsz write");
		chk8(fdata, 8'h00, "decsz data");
		issue({iobx_pkg::OP_OR_LIT, 8'h7E});
		chk8(accum, 8'h81, "decsz hit");
		chk15(pc, pc_e, "decsz pc");
		issue(fop(iobx_pkg::OP_INC_SKIP, 1'b0, 7'h32));
		chk8(accum, 8'h00, "incsz to w");
		chk1(zero, 1'b0, "incsz flag");
		issue({iobx_pkg::OP_OR_LIT, 8'h01});
		chk8(accum, 8'h00, "incsz hit");
		chk15(pc, pc_e, "incsz pc");
		issue(fop(iobx_pkg::OP_INC_SKIP, 1'b1, 7'h30));
		chk1(fwe, 1'b1, "incsz write");
		chk8(fdata, 8'h03, "incsz data");
		chk8(accum, 8'h00, "incsz w kept");
		issue({iobx_pkg::OP_OR_LIT, 8'h02});
		chk8(accum, 8'h02, "after skip");
		$display("test skip done");
	endtask

	// latch bits 2:0 and 4:3 differ from 6:3 on purpose
	task automatic t_branch();
		latch = 7'h7F;
		issue({iobx_pkg::OP_BRANCH, 11'h7FF});
		pc_e = 15'h7FFF;
		chk15(pc, pc_e, "br max");
		chk1(zero, 1'b0, "br flag");
		issue({iobx_pkg::OP_OR_LIT, 8'h40});
		pc_e = 15'h7FFF;
		chk15(pc, pc_e, "br drop pc");
		chk8(accum, 8'h02, "br drop w");
		latch = 7'h47;
		issue({iobx_pkg::OP_BRANCH, 11'h005});
		pc_e = 15'h4005;
		chk15(pc, pc_e, "br high");
		issue({iobx_pkg::OP_OR_LIT, 8'h40});
		pc_e = 15'h4005;
		issue({iobx_pkg::OP_OR_LIT, 8'h40});
		chk15(pc, pc_e, "br resume");
		chk8(accum, 8'h42, "br resume w");
		$display("test branch done");
	endtask

	// main sequence: hold reset two cycles, then each scenario
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		t_dec();
		t_or();
		t_ready();
		t_inc();
		t_skip();
		t_branch();
		final_report();
	end
endmodule
